/* File: sctmr_cfg.svh */
// constants for the six-channel timer: register map, fields, reset values
// assumes a 32-bit avalon-mm slave with word addressing by byte address
`ifndef SCTMR_CFG_SVH
`define SCTMR_CFG_SVH

`define SCTMR_OFS_START_A    8'h00
`define SCTMR_OFS_START_B    8'h04
`define SCTMR_OFS_PRESCALE   8'h08
`define SCTMR_OFS_IRQ_STAT   8'h0c
`define SCTMR_OFS_MODE0      8'h20
`define SCTMR_OFS_COUNT0     8'h40

`define SCTMR_MODE_RST       8'h00
`define SCTMR_PRESCALE_RST   4'h0
`define SCTMR_SLOW_DIV       5'h1f
`define SCTMR_FAST_DIV       3'h7

// mode register fields
`define SCTMR_F_OPMODE_LO    0
`define SCTMR_F_OPMODE_HI    1
`define SCTMR_F_EDGE_LO      2
`define SCTMR_F_EDGE_HI      3
`define SCTMR_F_WIDTH        4
`define SCTMR_F_OVF          5
`define SCTMR_F_CHAIN        5
`define SCTMR_F_SRC_LO       6
`define SCTMR_F_SRC_HI       7

`endif

/* File: sctmr_pkg.sv */
// types shared by the six-channel timer
// assumes sctmr_cfg.svh holds the numeric constants
package sctmr_pkg;

    typedef enum logic [1:0] {
        SCTMR_MODE_TIMER = 2'h0,
        SCTMR_MODE_EVENT = 2'h1,
        SCTMR_MODE_MEAS  = 2'h2,
        SCTMR_MODE_RSVD  = 2'h3
    } sctmr_mode_t;

    typedef enum logic [1:0] {
        SCTMR_EDGE_FALL = 2'h0,
        SCTMR_EDGE_RISE = 2'h1,
        SCTMR_EDGE_BOTH = 2'h2,
        SCTMR_EDGE_NONE = 2'h3
    } sctmr_edge_t;

endpackage

/* File: sctmr_top.sv */
// six independent 16-bit timer channels behind an avalon-mm slave
// assumes channel input pins and slow_tick synchronous to sys_clk
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "sctmr_cfg.svh"

// Summary of operation
// - two-bit field picks timer, event, measure mode
// - timer source: undivided, div8, prescaled, slow
// - prescale field: zero undivided, else 2^n
// - timer mode decrements, reloads on underflow
// - value n underflows every n+1 pulses
// - run bit 1 starts, 0 stops
// - underflow raises interrupt in timer/event modes
// - count read gives live counter there
// - stopped write loads both; running, reload only
// - event source: pin edge or chained underflow
// - event mode decrements, reloads, keeps counting
// - measure: count up, capture and clear on edge
// - measure irq on edge and overflow, not first
// - overflow flag cleared after run and pulse
// - measure read returns captured reload value
// - capture undefined before second valid edge
// - measure mode ignores count register writes
module sctmr_top
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // channel pins and low-speed tick
    input  wire logic [5:0]  channel_input_pin,
    input  wire logic        slow_tick,
    // interrupt requests, one pulse per event
    output logic      [5:0]  chan_irq_ff
);

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle per access, answer on the second edge
    logic        ack_ff;
    logic        req;
    logic        wr_go;
    logic [5:0]  wr_mode_sel;
    logic [5:0]  wr_cnt_sel;

    assign req   = (avs_read || avs_write) && !ack_ff;
    assign wr_go = avs_write && ack_ff;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_ff          <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else if (clk_en)
        begin
            ack_ff          <= req;
            avs_waitrequest <= !req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared count sources
    logic [3:0]  prescale_divide_field_ff;
    logic [14:0] pre_cnt_ff;
    logic [2:0]  div8_cnt_ff;
    logic [4:0]  slow_cnt_ff;
    logic        sys_clock_div8;
    logic        prescaled_clock;
    logic        slow_clock_div32;
    logic [15:0] pre_limit;
    // limit 2^n - 1 for settings 1..15
    assign pre_limit        = (16'h0001 << prescale_divide_field_ff) - 16'h0001;
    assign prescaled_clock  = (prescale_divide_field_ff == 4'h0) ||
                              ({1'b0, pre_cnt_ff} == pre_limit);
    assign sys_clock_div8   = (div8_cnt_ff == `SCTMR_FAST_DIV);
    assign slow_clock_div32 = slow_tick && (slow_cnt_ff == `SCTMR_SLOW_DIV);
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pre_cnt_ff  <= 15'h0000;
            div8_cnt_ff <= 3'h0;
            slow_cnt_ff <= 5'h00;
        end
        else if (clk_en)
        begin
            pre_cnt_ff  <= prescaled_clock ? 15'h0000 : pre_cnt_ff + 15'h0001;
            div8_cnt_ff <= div8_cnt_ff + 3'h1;
            if (slow_tick)
                slow_cnt_ff <= slow_cnt_ff + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    logic [5:0]  channel_run_bit_ff;
    logic [5:0]  run_q_ff;
    logic [7:0]  channel_mode_reg_ff [6];
    logic [5:0]  pin_q_ff;
    logic [5:0]  pin_edge;
    logic [5:0]  src_tick;
    logic [5:0]  uflow;
    logic [5:0]  oflow;
    logic [5:0]  ovf_ff;
    logic [5:0]  ovf_armed_ff;
    logic [5:0]  first_seen_ff;
    logic [5:0]  irq_stat_ff;
    logic [15:0] count_ff  [6];
    logic [15:0] reload_ff [6];
    // decoded byte address to channel one-hot
    function automatic logic [5:0] sel_chan(input logic [7:0] addr, input logic [7:0] base);
        logic [5:0] sel;
        sel = 6'h00;
        for (int i = 0; i < 6; i++)
        begin
            if (addr == base + 8'(4 * i))
                sel[i] = 1'b1;
        end
        return sel;
    endfunction
    assign wr_mode_sel = wr_go ? sel_chan(avs_address, `SCTMR_OFS_MODE0)  : 6'h00;
    assign wr_cnt_sel  = wr_go ? sel_chan(avs_address, `SCTMR_OFS_COUNT0) : 6'h00;
    // start flags: channels 0-2 in register a, 3-5 in register b
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            channel_run_bit_ff <= 6'h00;
        else if (clk_en && wr_go && avs_address == `SCTMR_OFS_START_A)
            channel_run_bit_ff[2:0] <= avs_writedata[2:0];
        else if (clk_en && wr_go && avs_address == `SCTMR_OFS_START_B)
            channel_run_bit_ff[5:3] <= avs_writedata[2:0];
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            prescale_divide_field_ff <= `SCTMR_PRESCALE_RST;
        else if (clk_en && wr_go && avs_address == `SCTMR_OFS_PRESCALE)
            prescale_divide_field_ff <= avs_writedata[3:0];
    end
    // pins taken as synchronous; one stage for edge reference
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_q_ff <= 6'h00;
            run_q_ff <= 6'h00;
        end
        else if (clk_en)
        begin
            pin_q_ff <= channel_input_pin;
            run_q_ff <= channel_run_bit_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel logic
    for (genvar c = 0; c < 6; c++)
    begin : g_chan
        localparam int PREV = (c == 0) ? 2 : (c == 3) ? 5 : c - 1;
        sctmr_pkg::sctmr_mode_t mode;
        sctmr_pkg::sctmr_edge_t edge_sel;
        logic rise;
        logic fall;
        logic int_tick;
        logic ovf_clr;
        assign mode     = sctmr_pkg::sctmr_mode_t'(channel_mode_reg_ff[c][1:0]);
        assign edge_sel = sctmr_pkg::sctmr_edge_t'(channel_mode_reg_ff[c][3:2]);
        assign rise     = channel_input_pin[c] && !pin_q_ff[c];
        assign fall     = !channel_input_pin[c] && pin_q_ff[c];
        // width measurement uses both edges, period one polarity
        always_comb
        begin
            if (mode == sctmr_pkg::SCTMR_MODE_MEAS && channel_mode_reg_ff[c][4])
                pin_edge[c] = rise || fall;
            else
            begin
                case (edge_sel)
                    sctmr_pkg::SCTMR_EDGE_FALL: pin_edge[c] = fall;
                    sctmr_pkg::SCTMR_EDGE_RISE: pin_edge[c] = rise;
                    sctmr_pkg::SCTMR_EDGE_BOTH: pin_edge[c] = rise || fall;
                    default:                    pin_edge[c] = 1'b0;
                endcase
            end
        end
        // internal source pick
        always_comb
        begin
            case (channel_mode_reg_ff[c][7:6])
                2'h0:    int_tick = 1'b1;
                2'h1:    int_tick = sys_clock_div8;
                2'h2:    int_tick = prescaled_clock;
                default: int_tick = slow_clock_div32;
            endcase
        end
        // event source: pin edge or chained_channel underflow
        assign src_tick[c] = (mode == sctmr_pkg::SCTMR_MODE_EVENT) ?
                             (channel_mode_reg_ff[c][`SCTMR_F_CHAIN] ? uflow[PREV]
                                                                     : pin_edge[c])
                             : int_tick;
        assign uflow[c] = channel_run_bit_ff[c] && src_tick[c] &&
                          mode != sctmr_pkg::SCTMR_MODE_MEAS &&
                          count_ff[c] == 16'h0000;
        assign oflow[c] = channel_run_bit_ff[c] && src_tick[c] &&
                          mode == sctmr_pkg::SCTMR_MODE_MEAS &&
                          count_ff[c] == 16'hffff;
        // clear only once armed by a source pulse while running
        assign ovf_clr = wr_mode_sel[c] && ovf_armed_ff[c] && !avs_writedata[`SCTMR_F_OVF];
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                channel_mode_reg_ff[c] <= `SCTMR_MODE_RST;
            else if (clk_en && wr_mode_sel[c])
                channel_mode_reg_ff[c] <= avs_writedata[7:0];
        end
        // overflow sets win over clear
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
            begin
                ovf_ff[c]       <= 1'b0;
                ovf_armed_ff[c] <= 1'b0;
            end
            else if (clk_en)
            begin
                if (oflow[c])
                begin
                    ovf_ff[c]       <= 1'b1;
                    ovf_armed_ff[c] <= 1'b0;
                end
                else
                begin
                    if (ovf_clr)
                        ovf_ff[c] <= 1'b0;
                    if (ovf_ff[c] && channel_run_bit_ff[c] && src_tick[c])
                        ovf_armed_ff[c] <= 1'b1;
                    else if (ovf_clr)
                        ovf_armed_ff[c] <= 1'b0;
                end
            end
        end
        // counter and reload
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
            begin
                count_ff[c]  <= 16'h0000;
                reload_ff[c] <= 16'h0000;
            end
            else if (clk_en)
            begin
                if (mode == sctmr_pkg::SCTMR_MODE_MEAS)
                begin
                    // count writes dropped here
                    if (channel_run_bit_ff[c] && pin_edge[c])
                    begin
                        reload_ff[c] <= count_ff[c];
                        count_ff[c]  <= 16'h0000;
                    end
                    else if (channel_run_bit_ff[c] && src_tick[c])
                        count_ff[c] <= count_ff[c] + 16'h0001;
                end
                else
                begin
                    if (wr_cnt_sel[c])
                        reload_ff[c] <= avs_writedata[15:0];
                    if (wr_cnt_sel[c] && !channel_run_bit_ff[c])
                        count_ff[c] <= avs_writedata[15:0];
                    else if (uflow[c])
                        count_ff[c] <= wr_cnt_sel[c] ? avs_writedata[15:0]
                                                     : reload_ff[c];
                    else if (channel_run_bit_ff[c] && src_tick[c])
                        count_ff[c] <= count_ff[c] - 16'h0001;
                end
            end
        end
        // first edge after start raises nothing
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                first_seen_ff[c] <= 1'b0;
            else if (clk_en)
            begin
                if (channel_run_bit_ff[c] && !run_q_ff[c])
                    first_seen_ff[c] <= 1'b0;
                else if (channel_run_bit_ff[c] && pin_edge[c] &&
                         mode == sctmr_pkg::SCTMR_MODE_MEAS)
                    first_seen_ff[c] <= 1'b1;
            end
        end
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                chan_irq_ff[c] <= 1'b0;
            else if (clk_en)
                chan_irq_ff[c] <= uflow[c] || oflow[c] ||
                                  (mode == sctmr_pkg::SCTMR_MODE_MEAS && pin_edge[c] &&
                                   first_seen_ff[c] && channel_run_bit_ff[c] &&
                                   run_q_ff[c]);
        end
        // sticky status copy for polling; set wins over clear
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                irq_stat_ff[c] <= 1'b0;
            else if (clk_en)
            begin
                if (chan_irq_ff[c])
                    irq_stat_ff[c] <= 1'b1;
                else if (wr_go && avs_address == `SCTMR_OFS_IRQ_STAT && avs_writedata[c])
                    irq_stat_ff[c] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, registered at the request edge and held for the answer edge
    logic [31:0] nxt_rdata;
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (avs_address == `SCTMR_OFS_START_A)
            nxt_rdata = {29'h0, channel_run_bit_ff[2:0]};
        else if (avs_address == `SCTMR_OFS_START_B)
            nxt_rdata = {29'h0, channel_run_bit_ff[5:3]};
        else if (avs_address == `SCTMR_OFS_PRESCALE)
            nxt_rdata = {28'h0, prescale_divide_field_ff};
        else if (avs_address == `SCTMR_OFS_IRQ_STAT)
            nxt_rdata = {26'h0, irq_stat_ff};
        else
        begin
            for (int i = 0; i < 6; i++)
            begin
                if (avs_address == `SCTMR_OFS_MODE0 + 8'(4 * i))
                    nxt_rdata = {24'h0, channel_mode_reg_ff[i][7:6],
                                 channel_mode_reg_ff[i][1:0] == 2'h2 ? ovf_ff[i]
                                     : channel_mode_reg_ff[i][5],
                                 channel_mode_reg_ff[i][4:0]};
                else if (avs_address == `SCTMR_OFS_COUNT0 + 8'(4 * i))
                    nxt_rdata = {16'h0, channel_mode_reg_ff[i][1:0] == 2'h2 ?
                                 reload_ff[i] : count_ff[i]};
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (clk_en && req)
            avs_readdata <= nxt_rdata;
    end

endmodule // sctmr_top

/* File: sctmr_properties.sv */
// checker for the six-channel timer: bus handshake, readback, quiet stop
// assumes it is bound to sctmr_top and sees only that module's ports
`timescale 1ns/100ps
`include "sctmr_cfg.svh"
module sctmr_properties
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    // avalon-mm slave
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // pins and irqs
    input wire logic [5:0]  channel_input_pin,
    input wire logic        slow_tick,
    input wire logic [5:0]  chan_irq_ff
);
    // shadows of what software wrote, taken at the accepting edge
    logic [7:0] mode_ff [8];
    logic [5:0] run_ff;
    logic [3:0] pre_ff;
    logic       req;
    logic       wr_ok;
    logic       mode_ad;
    logic [6:0] mode_key;
    assign req = (avs_read || avs_write) && avs_waitrequest && clk_en;
    assign wr_ok = avs_write && !avs_waitrequest && clk_en;
    assign mode_ad = avs_address[7:5] == 3'h1 && avs_address[4:2] < 3'h6;
    // bit 5 left out: in measure mode it reads the overflow flag
    assign mode_key = {mode_ff[avs_address[4:2]][7:6], mode_ff[avs_address[4:2]][4:0]};
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            run_ff <= 6'h00;
            pre_ff <= 4'h0;
            for (int i = 0; i < 8; i++)
                mode_ff[i] <= 8'h00;
        end
        else if (wr_ok)
        begin
            if (avs_address == `SCTMR_OFS_START_A)
                run_ff[2:0] <= avs_writedata[2:0];
            if (avs_address == `SCTMR_OFS_START_B)
                run_ff[5:3] <= avs_writedata[2:0];
            if (avs_address == `SCTMR_OFS_PRESCALE)
                pre_ff <= avs_writedata[3:0];
            if (mode_ad)
                mode_ff[avs_address[4:2]] <= avs_writedata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_ack;
        req ##1 !avs_waitrequest;
    endsequence
    sequence s_idle;
        !avs_read && !avs_write && avs_waitrequest && clk_en;
    endsequence
    property p_wait_ack;
        req |=> !avs_waitrequest;
    endproperty
    a_wait_ack: assert property (p_wait_ack) else $error("request not answered next cycle");
    property p_wait_one;
        s_ack |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer held over one cycle");
    property p_wait_idle;
        s_idle |=> avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
    property p_rdata_hold;
        s_idle |=> $stable(avs_readdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved while idle");
    property p_unmapped;
        avs_read && avs_address[7:6] == 2'h3 && req |=> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pre_rd;
        avs_read && avs_address == `SCTMR_OFS_PRESCALE && req
            |=> avs_readdata[3:0] == $past(pre_ff);
    endproperty
    a_pre_rd: assert property (p_pre_rd) else $error("prescale readback wrong");
    property p_mode_rd;
        avs_read && mode_ad && req
            |=> {avs_readdata[7:6], avs_readdata[4:0]} == $past(mode_key);
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
    property p_stop_quiet;
        (chan_irq_ff & ~(run_ff | $past(run_ff) | $past(run_ff, 2) | $past(run_ff, 3))) == 6'h00;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("irq from stopped channel");
endmodule // sctmr_properties

bind sctmr_top sctmr_properties u_props
(
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .channel_input_pin(channel_input_pin), .slow_tick(slow_tick), .chan_irq_ff(chan_irq_ff)
);

/* File: sctmr_pulse_src.sv */
// far-side pulse source: one square wave per channel input pin
// assumes en and half come from the bench, synchronous to sys_clk
`timescale 1ns/100ps
module sctmr_pulse_src
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // control
    input wire logic [5:0] en,
    input wire logic [7:0] half,
    // pins
    output logic     [5:0] pin_ff
);
    logic [7:0] cnt_ff [6];
    // counter restarts while disabled so the first edge lands at a known cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_ff <= 6'h00;
            for (int i = 0; i < 6; i++)
                cnt_ff[i] <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 6; i++)
            begin
                if (!en[i])
                    cnt_ff[i] <= 8'h00;
                else if (cnt_ff[i] == half - 8'h01)
                begin
                    cnt_ff[i] <= 8'h00;
                    pin_ff[i] <= ~pin_ff[i];
                end
                else
                    cnt_ff[i] <= cnt_ff[i] + 8'h01;
            end
        end
    end
endmodule // sctmr_pulse_src

/* File: test_sctmr_top.sv */
// self-checking bench for the six-channel timer
// assumes sctmr_pulse_src drives the pins; clk_en drops once for a freeze test
`timescale 1ns/100ps
`include "sctmr_cfg.svh"
module test_sctmr_top;
    typedef struct {int ch; logic [7:0] md; logic [15:0] n; int gap;} sctmr_row_t;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic        slow_tick = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q, q2;
    logic        avs_waitrequest;
    logic [5:0]  pins, irq;
    logic [5:0]  pen = 6'h30;
    logic [5:0]  rm = 6'h00;
    int          errors = 0;
    int          n_tests = 0;
    int          g, c;
    sctmr_row_t  r;
    // channel, mode byte, count, expected irq spacing in cycles
    sctmr_row_t  rows [13] = '{
        '{0, 8'h00, 16'h4, 5}, '{1, 8'h40, 16'h2, 24}, '{2, 8'h80, 16'h1, 16},
        '{0, 8'h21, 16'h0, 16}, '{3, 8'hc0, 16'h0, 64}, '{4, 8'h01, 16'h2, 30},
        '{4, 8'h09, 16'h2, 15}, '{4, 8'h05, 16'h2, 30}, '{5, 8'h21, 16'h1, 60},
        '{3, 8'h21, 16'h0, 60}, '{5, 8'h12, 16'h0, 5}, '{5, 8'h06, 16'h0, 10},
        '{5, 8'h02, 16'h0, 10}};
    sctmr_top uut
    (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .channel_input_pin(pins), .slow_tick(slow_tick), .chan_irq_ff(irq)
    );
    sctmr_pulse_src u_src
    (
        .sys_clk(sys_clk), .rst(rst), .en(pen), .half(8'h05), .pin_ff(pins)
    );
    always #10 sys_clk = ~sys_clk;
    // slow tick every other cycle, so the slow source is one pulse in 64
    always @(posedge sys_clk) slow_tick <= ~slow_tick;
    ////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one bus access; the trailing idle edge keeps strobes from re-rising in one step
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
        if (k >= 50)
        begin
            errors++;
            print_verdict;
        end
    endtask
    task set_run;
        bus(1'b1, `SCTMR_OFS_START_A, {29'h0, rm[2:0]});
        bus(1'b1, `SCTMR_OFS_START_B, {29'h0, rm[5:3]});
    endtask
    task wait_irq(input int ch);
        g = 0;
        do begin @(posedge sys_clk); g++; end while (irq[ch] !== 1'b1 && g < 4000);
        if (g >= 4000)
        begin
            errors++;
            print_verdict;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge sys_clk);
        chk("irq in reset", 32'h0, {26'h0, irq});
        rst <= 1'b0;
        bus(1'b0, `SCTMR_OFS_MODE0, 32'h0);
        chk("mode reset", {24'h0, `SCTMR_MODE_RST}, q);
        bus(1'b0, `SCTMR_OFS_PRESCALE, 32'h0);
        chk("prescale reset", {28'h0, `SCTMR_PRESCALE_RST}, q);
        bus(1'b1, 8'hf0, 32'hffffffff);
        bus(1'b0, 8'hf0, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, `SCTMR_OFS_COUNT0 + 8'h14, 32'h1234);
        bus(1'b0, `SCTMR_OFS_COUNT0 + 8'h14, 32'h0);
        chk("stopped count", 32'h1234, {16'h0, q[15:0]});
        bus(1'b1, `SCTMR_OFS_PRESCALE, 32'h3);
        $display("reset and map test done");
        foreach (rows[i])
        begin
            r = rows[i];
            rm[r.ch] = 1'b0;
            set_run;
            bus(1'b1, `SCTMR_OFS_MODE0 + 8'(4 * r.ch), {24'h0, r.md});
            bus(1'b1, `SCTMR_OFS_COUNT0 + 8'(4 * r.ch), {16'h0, r.n});
            rm[r.ch] = 1'b1;
            set_run;
            wait_irq(r.ch);
            wait_irq(r.ch);
            chk("irq spacing", 32'(r.gap), 32'(g));
            $display("row %0d done", i);
        end
        // reload written while running takes effect only at the next reload
        bus(1'b1, `SCTMR_OFS_COUNT0 + 8'h08, 32'h3);
        repeat (3) wait_irq(2);
        chk("running write", 32'd32, 32'(g));
        $display("running write test done");
        // a low enable must hold every flop; ch5 would pulse within 30 cycles
        clk_en <= 1'b0;
        @(posedge sys_clk);
        q2 = {26'h0, irq};
        c = 0;
        repeat (30)
        begin
            @(posedge sys_clk);
            if ({26'h0, irq} !== q2)
                c++;
        end
        clk_en <= 1'b1;
        chk("frozen irq", 32'h0, 32'(c));
        $display("enable test done");
        rm[1] = 1'b0;
        set_run;
        bus(1'b1, `SCTMR_OFS_MODE0 + 8'h04, 32'h12);
        rm[1] = 1'b1;
        set_run;
        pen[1] <= 1'b1;
        c = 0;
        for (int k = 0; k < 40; k++)
        begin
            @(posedge sys_clk);
            if (k == 16)
                pen[1] <= 1'b0;
            if (irq[1] === 1'b1)
                c++;
        end
        chk("first edge silent", 32'd2, 32'(c));
        pen[1] <= 1'b1;
        repeat (40) @(posedge sys_clk);
        bus(1'b0, `SCTMR_OFS_COUNT0 + 8'h04, 32'h0);
        q2 = q;
        chk("width value", 32'h1, {31'h0, q2 == 32'h5 || q2 == 32'h4});
        bus(1'b1, `SCTMR_OFS_COUNT0 + 8'h04, 32'hffff);
        repeat (20) @(posedge sys_clk);
        bus(1'b0, `SCTMR_OFS_COUNT0 + 8'h04, 32'h0);
        chk("capture held", q2, q);
        $display("measure test done");
        // preload near the top in timer mode so the overflow comes quickly
        rm[0] = 1'b0;
        set_run;
        bus(1'b1, `SCTMR_OFS_MODE0, 32'h0);
        bus(1'b1, `SCTMR_OFS_COUNT0, 32'hfff0);
        bus(1'b1, `SCTMR_OFS_MODE0, 32'h0e);
        rm[0] = 1'b1;
        set_run;
        wait_irq(0);
        bus(1'b0, `SCTMR_OFS_MODE0, 32'h0);
        chk("overflow flag", 32'h2e, q);
        bus(1'b1, `SCTMR_OFS_MODE0, 32'h0e);
        bus(1'b0, `SCTMR_OFS_MODE0, 32'h0);
        chk("overflow clear", 32'h0e, q);
        $display("overflow test done");
        bus(1'b0, `SCTMR_OFS_IRQ_STAT, 32'h0);
        chk("irq status", 32'h3f, {26'h0, q[5:0]});
        rm = 6'h00;
        set_run;
        repeat (10) @(posedge sys_clk);
        bus(1'b1, `SCTMR_OFS_IRQ_STAT, 32'h3f);
        bus(1'b0, `SCTMR_OFS_IRQ_STAT, 32'h0);
        chk("irq cleared", 32'h0, {26'h0, q[5:0]});
        c = 0;
        repeat (300)
        begin
            @(posedge sys_clk);
            if (irq !== 6'h00)
                c++;
        end
        chk("stopped quiet", 32'h0, 32'(c));
        $display("stop test done");
        print_verdict;
    end
endmodule // test_sctmr_top
